// ===== design/serial_channel.sv
/*
  async serial channel: full duplex transmitter and receiver with a
  double buffered transmit path, three interrupt pulses and an
  axi4-lite register slave.
  assumes i_baud_tick is a one-cycle enable at 16x the bit rate from an
  outside baud generator, and that i_rx_line is already synchronous.
*/
// Operation
// - three interrupts, priority rx done, tx, error; code has no priority, three separate lines
// - rx done pulse when frame reaches buffer
// - errors go to error or done irq
// - route 0 error irq, route 1 done
// - no rx done irq while rx disabled
// - error irq is or of errors, enabled
// - tx done after 7 or 8 bit frame
// - start, data lsb first, parity, stop
// - transmitter and receiver run independently
// - char length 7 or 8, bit7 zero
// - stop length for tx; rx checks one
// - unit enable drives line idle high
// - tx enable gates; buffer write starts tx
// - buffer loads shifter, start bit first
// - tx done with last stop bit
// - no new data means line idles
// - no tx done from reset
// - next byte accepted once shifting starts
// - buffer full flag gates writes; a write while full overwrites tx_buffer
// - shift busy while frame in flight
// - flags go 10, 11, 01
// - flags 00 after enable, then sequence
// - falling edge, start confirmed mid bit
// - shift bits at rate, one irq/frame
// - even/odd parity error on ones count
`timescale 1ns/1ps
`default_nettype none
`include "serial_channel_defs.svh"

module serial_channel
  import serial_channel_pkg::*;
#(
  parameter int DATA_W = 8                    // character register width
) (
  input  wire logic        i_clk,             // base clock, 40 mhz
  input  wire logic        i_rst,             // async reset, active high
  input  wire logic        i_baud_tick,       // 16x bit rate enable
  input  wire logic        i_rx_line,         // serial input
  output logic             o_tx_line,         // serial output
  output logic             o_rx_done_irq,     // receive complete pulse
  output logic             o_tx_done_irq,     // transmit complete pulse
  output logic             o_rx_err_irq,      // receive error pulse
  input  wire logic [7:0]  i_awaddr,          // write address
  input  wire logic        i_awvalid,         // write address valid
  output logic             o_awready,         // write address ready
  input  wire logic [31:0] i_wdata,           // write data
  input  wire logic [3:0]  i_wstrb,           // write byte strobes
  input  wire logic        i_wvalid,          // write data valid
  output logic             o_wready,          // write data ready
  output logic [1:0]       o_bresp,           // write response
  output logic             o_bvalid,          // write response valid
  input  wire logic        i_bready,          // write response ready
  input  wire logic [7:0]  i_araddr,          // read address
  input  wire logic        i_arvalid,         // read address valid
  output logic             o_arready,         // read address ready
  output logic [31:0]      o_rdata,           // read data
  output logic [1:0]       o_rresp,           // read response
  output logic             o_rvalid,          // read data valid
  input  wire logic        i_rready           // read data ready
);

  // whole module state in one record
  typedef struct packed {
    logic [7:0]        mode;       // serial_mode_reg
    logic [2:0]        err;        // rx_error_flags
    logic [DATA_W-1:0] rx_buffer;  // received character
    logic [DATA_W-1:0] tx_buffer;  // pending character
    logic              buf_full;   // tx_buf_full
    logic              shift_busy; // tx_shift_busy
    logic              rx_unread;  // rx_buffer not yet read
    tx_state_t         tx_st;      // transmit sequencer
    logic [DATA_W-1:0] tx_shift;   // transmit shifter
    logic [3:0]        tx_tick;    // ticks within tx bit
    logic [2:0]        tx_bit;     // tx bit index
    logic              tx_stop2;   // second stop pending
    logic              tx_line;    // line level
    rx_state_t         rx_st;      // receive sequencer
    logic [DATA_W-1:0] rx_shift;   // receive shifter
    logic [3:0]        rx_tick;    // ticks within rx bit
    logic [2:0]        rx_bit;     // rx bit index
    logic              rx_par;     // running ones parity
    logic              rx_prev;    // last line level
    logic              irq_rx;     // rx done pulse
    logic              irq_tx;     // tx done pulse
    logic              irq_err;    // rx error pulse
    logic              aw_got;     // address latched
    logic              w_got;      // data latched
    logic [7:0]        awaddr;     // held write address
    logic [31:0]       wdata;      // held write data
    logic [3:0]        wstrb;      // held strobes
    logic              bvalid;     // write response pending
    logic [1:0]        bresp;      // write response code
    logic              rvalid;     // read data pending
    logic [31:0]       rdata;      // read data
    logic [1:0]        rresp;      // read response code
  } state_t;

  state_t st_r;   // registered state
  state_t st_nxt; // next state

  // last character bit index from mode, 6 or 7
  function automatic logic [2:0] last_bit(input logic [7:0] m);
    last_bit = m[`MODE_CHAR_LEN] ? 3'd7 : 3'd6;
  endfunction

  // odd-ones parity over the active character bits
  function automatic logic ones_odd(input logic [DATA_W-1:0] d, input logic [7:0] m);
    ones_odd = m[`MODE_CHAR_LEN] ? ^d : ^d[6:0];
  endfunction

  // next-state logic for bus, transmitter and receiver
  always_comb begin
    logic          unit_en;
    logic          tx_en;
    logic          rx_en;
    parity_mode_t  pmode;
    logic          do_wr;
    logic          bit_end_tx;
    logic          mid_rx;
    logic          frame_err;
    logic          par_err;
    logic [2:0]    new_err;
    logic [DATA_W-1:0] rx_char;
    unit_en    = 1'b0;
    tx_en      = 1'b0;
    rx_en      = 1'b0;
    pmode      = PAR_NONE;
    do_wr      = 1'b0;
    bit_end_tx = 1'b0;
    mid_rx     = 1'b0;
    frame_err  = 1'b0;
    par_err    = 1'b0;
    new_err    = 3'b000;
    rx_char    = '0;
    st_nxt     = st_r;

    unit_en = st_r.mode[`MODE_UNIT_EN];
    tx_en   = unit_en & st_r.mode[`MODE_TX_EN];
    rx_en   = unit_en & st_r.mode[`MODE_RX_EN];
    pmode   = parity_mode_t'(st_r.mode[`MODE_PAR_HI:`MODE_PAR_LO]);

    // interrupt pulses last one cycle
    st_nxt.irq_rx  = 1'b0;
    st_nxt.irq_tx  = 1'b0;
    st_nxt.irq_err = 1'b0;

    // axi write: take address and data in either order
    if (i_awvalid && !st_r.aw_got) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.awaddr = i_awaddr;
    end
    if (i_wvalid && !st_r.w_got) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = i_wdata;
      st_nxt.wstrb = i_wstrb;
    end
    do_wr = st_r.aw_got && st_r.w_got && !st_r.bvalid;
    if (do_wr) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got  = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp  = `RESP_OKAY;
      unique case (st_r.awaddr)
        `OFS_MODE: begin
          if (st_r.wstrb[0]) st_nxt.mode = st_r.wdata[7:0];
        end
        `OFS_TXBUF: begin
          // ignored while transmit disabled
          if (st_r.wstrb[0] && tx_en) begin
            st_nxt.tx_buffer = st_r.wdata[DATA_W-1:0];
            st_nxt.buf_full  = 1'b1;
          end
        end
        `OFS_ERR, `OFS_TXSTAT, `OFS_RXBUF: begin
          // read-only, write dropped
        end
        default: st_nxt.bresp = `RESP_SLVERR;
      endcase
    end
    if (st_r.bvalid && i_bready) st_nxt.bvalid = 1'b0;

    // axi read: answer one cycle after the address is taken
    if (i_arvalid && !st_r.rvalid) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp  = `RESP_OKAY;
      st_nxt.rdata  = 32'h0000_0000;
      unique case (i_araddr)
        `OFS_MODE:   st_nxt.rdata[7:0] = st_r.mode;
        `OFS_ERR: begin
          st_nxt.rdata[2:0] = st_r.err;
          st_nxt.err        = 3'b000; // cleared by read
        end
        `OFS_TXSTAT: begin
          st_nxt.rdata[`TXS_BUF_FULL]   = st_r.buf_full;
          st_nxt.rdata[`TXS_SHIFT_BUSY] = st_r.shift_busy;
        end
        `OFS_RXBUF: begin
          st_nxt.rdata[DATA_W-1:0] = st_r.rx_buffer;
          st_nxt.rx_unread         = 1'b0;
        end
        `OFS_TXBUF:  st_nxt.rdata[DATA_W-1:0] = st_r.tx_buffer;
        default:     st_nxt.rresp = `RESP_SLVERR;
      endcase
    end
    if (st_r.rvalid && i_rready) st_nxt.rvalid = 1'b0;

    // transmitter, independent of the receiver
    bit_end_tx = i_baud_tick && (st_r.tx_tick == 4'(`TICKS_PER_BIT - 1));
    if (i_baud_tick && st_r.tx_st != TX_IDLE)
      st_nxt.tx_tick = st_r.tx_tick + 4'd1;
    if (!tx_en) begin
      // disabled: flags clear, line idles high while unit on
      st_nxt.tx_st      = TX_IDLE;
      st_nxt.buf_full   = 1'b0;
      st_nxt.shift_busy = 1'b0;
      st_nxt.tx_line    = 1'b1;
    end else begin
      unique case (st_r.tx_st)
        TX_IDLE: begin
          st_nxt.tx_line = 1'b1;
          if (st_r.buf_full) begin
            // move buffer into shifter and open with the start bit
            st_nxt.tx_shift   = st_r.tx_buffer;
            st_nxt.buf_full   = 1'b0;
            st_nxt.shift_busy = 1'b1;
            st_nxt.tx_line    = 1'b0;
            st_nxt.tx_tick    = 4'd0;
            st_nxt.tx_st      = TX_START;
          end
        end
        TX_START: begin
          if (bit_end_tx) begin
            st_nxt.tx_line = st_r.tx_shift[0];
            st_nxt.tx_bit  = 3'd0;
            st_nxt.tx_st   = TX_DATA;
          end
        end
        TX_DATA: begin
          if (bit_end_tx) begin
            if (st_r.tx_bit == last_bit(st_r.mode)) begin
              if (pmode == PAR_NONE) begin
                st_nxt.tx_line  = 1'b1;
                st_nxt.tx_stop2 = st_r.mode[`MODE_STOP_LEN];
                st_nxt.tx_st    = TX_STOP;
              end else begin
                unique case (pmode)
                  PAR_EVEN: st_nxt.tx_line = ones_odd(st_r.tx_shift, st_r.mode);
                  PAR_ODD:  st_nxt.tx_line = ~ones_odd(st_r.tx_shift, st_r.mode);
                  default:  st_nxt.tx_line = 1'b0;
                endcase
                st_nxt.tx_st = TX_PARITY;
              end
            end else begin
              st_nxt.tx_bit  = st_r.tx_bit + 3'd1;
              st_nxt.tx_line = st_r.tx_shift[st_r.tx_bit + 3'd1];
            end
          end
        end
        TX_PARITY: begin
          if (bit_end_tx) begin
            st_nxt.tx_line  = 1'b1;
            st_nxt.tx_stop2 = st_r.mode[`MODE_STOP_LEN];
            st_nxt.tx_st    = TX_STOP;
          end
        end
        TX_STOP: begin
          if (bit_end_tx) begin
            if (st_r.tx_stop2) begin
              st_nxt.tx_stop2 = 1'b0;
            end else begin
              // frame ends with last stop bit; irq only from shifting
              st_nxt.irq_tx = 1'b1;
              st_nxt.tx_st  = TX_IDLE;
              if (st_r.buf_full) begin
                // back to back: next start bit right away
                st_nxt.tx_shift = st_r.tx_buffer;
                st_nxt.buf_full = 1'b0;
                st_nxt.tx_line  = 1'b0;
                st_nxt.tx_tick  = 4'd0;
                st_nxt.tx_st    = TX_START;
              end else begin
                st_nxt.shift_busy = 1'b0;
              end
            end
          end
        end
        default: st_nxt.tx_st = TX_IDLE;
      endcase
    end
    if (!unit_en) st_nxt.tx_line = 1'b1;

    // receiver
    mid_rx = i_baud_tick && (st_r.rx_tick == 4'(`TICK_MID - 1));
    if (i_baud_tick) begin
      st_nxt.rx_prev = i_rx_line;
      if (st_r.rx_st != RX_IDLE) st_nxt.rx_tick = st_r.rx_tick + 4'd1;
    end
    if (!rx_en) begin
      // disabled: stop at once, buffers kept, flags kept unless unit off, no irqs
      st_nxt.rx_st = RX_IDLE;
      if (!unit_en) st_nxt.err = 3'b000;
    end else begin
      unique case (st_r.rx_st)
        RX_IDLE: begin
          if (i_baud_tick && st_r.rx_prev && !i_rx_line) begin
            st_nxt.rx_tick = 4'd1;
            st_nxt.rx_st   = RX_START;
          end
        end
        RX_START: begin
          if (mid_rx) begin
            // still low at mid point: genuine start
            if (!i_rx_line) begin
              st_nxt.rx_st    = RX_DATA;
              st_nxt.rx_bit   = 3'd0;
              st_nxt.rx_shift = '0;
              st_nxt.rx_par   = 1'b0;
            end else begin
              st_nxt.rx_st = RX_IDLE;
            end
          end
        end
        RX_DATA: begin
          if (mid_rx) begin
            // lsb arrives first
            st_nxt.rx_shift[st_r.rx_bit] = i_rx_line;
            st_nxt.rx_par = st_r.rx_par ^ i_rx_line;
            if (st_r.rx_bit == last_bit(st_r.mode)) begin
              st_nxt.rx_st = (pmode == PAR_NONE) ? RX_STOP : RX_PARITY;
            end else begin
              st_nxt.rx_bit = st_r.rx_bit + 3'd1;
            end
          end
        end
        RX_PARITY: begin
          if (mid_rx) begin
            st_nxt.rx_par = st_r.rx_par ^ i_rx_line;
            st_nxt.rx_st  = RX_STOP;
          end
        end
        RX_STOP: begin
          if (mid_rx) begin
            // only the first stop bit is checked
            frame_err = !i_rx_line;
            par_err   = ((pmode == PAR_EVEN) && st_r.rx_par) ||
                        ((pmode == PAR_ODD) && !st_r.rx_par);
            new_err[`ERR_FRAMING] = frame_err;
            new_err[`ERR_PARITY]  = par_err;
            new_err[`ERR_OVERRUN] = st_r.rx_unread;
            st_nxt.err = st_nxt.err | new_err;
            rx_char = st_r.rx_shift;
            if (!st_r.mode[`MODE_CHAR_LEN]) rx_char[DATA_W-1] = 1'b0;
            if (!st_r.rx_unread) begin
              st_nxt.rx_buffer = rx_char;
              st_nxt.rx_unread = 1'b1;
            end
            if (new_err != 3'b000) begin
              // error routing by err_irq_route
              if (st_r.mode[`MODE_ERR_ROUTE]) st_nxt.irq_rx = 1'b1;
              else                             st_nxt.irq_err = 1'b1;
            end else begin
              st_nxt.irq_rx = 1'b1;
            end
            st_nxt.rx_st = RX_IDLE;
          end
        end
        default: st_nxt.rx_st = RX_IDLE;
      endcase
    end
  end

  // state register, reset restores all buffers and flags
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_r           <= '0;
      st_r.mode      <= `MODE_RST;
      st_r.rx_buffer <= `BUF_RST;
      st_r.tx_buffer <= `BUF_RST;
      st_r.tx_st     <= TX_IDLE;
      st_r.rx_st     <= RX_IDLE;
      st_r.tx_line   <= 1'b1;
      st_r.rx_prev   <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs; the three irqs are separate lines, priority is the cpu's
  assign o_tx_line     = st_r.tx_line;
  assign o_rx_done_irq = st_r.irq_rx;
  assign o_tx_done_irq = st_r.irq_tx;
  assign o_rx_err_irq  = st_r.irq_err;
  assign o_awready     = !st_r.aw_got;
  assign o_wready      = !st_r.w_got;
  assign o_bvalid      = st_r.bvalid;
  assign o_bresp       = st_r.bresp;
  assign o_arready     = !st_r.rvalid;
  assign o_rvalid      = st_r.rvalid;
  assign o_rdata       = st_r.rdata;
  assign o_rresp       = st_r.rresp;

endmodule
`default_nettype wire

// ===== design/serial_channel_defs.svh
/*
  constants for the async serial channel: register offsets, field
  positions, reset values and sampling counts.
  assumes inclusion by bare name from the design module and the testbench.
*/
`ifndef SERIAL_CHANNEL_DEFS_SVH
`define SERIAL_CHANNEL_DEFS_SVH

// register byte offsets on the axi4-lite slave
`define OFS_MODE        8'h00
`define OFS_ERR         8'h04
`define OFS_TXSTAT      8'h08
`define OFS_RXBUF       8'h0C
`define OFS_TXBUF       8'h10

// serial_mode_reg field positions
`define MODE_UNIT_EN    7
`define MODE_TX_EN      6
`define MODE_RX_EN      5
`define MODE_PAR_HI     4
`define MODE_PAR_LO     3
`define MODE_CHAR_LEN   2
`define MODE_STOP_LEN   1
`define MODE_ERR_ROUTE  0

// rx_error_flags field positions
`define ERR_PARITY      2
`define ERR_FRAMING     1
`define ERR_OVERRUN     0

// tx_status_flags field positions
`define TXS_BUF_FULL    1
`define TXS_SHIFT_BUSY  0

// reset values
`define MODE_RST        8'h01
`define BUF_RST         8'hFF

// ticks of the baud enable per bit, and mid-bit sampling point
`define TICKS_PER_BIT   16
`define TICK_MID        8

// axi response codes
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10

`endif

// ===== design/serial_channel_pkg.sv
/*
  types for the async serial channel.
  assumes serial_channel_defs.svh is on the include path.
*/
package serial_channel_pkg;
  // parity modes in the mode register
  typedef enum logic [1:0] {
    PAR_NONE = 2'b00,
    PAR_ZERO = 2'b01,
    PAR_ODD  = 2'b10,
    PAR_EVEN = 2'b11
  } parity_mode_t;

  // transmit sequencer, gray coded along start-data-parity-stop
  typedef enum logic [2:0] {
    TX_IDLE   = 3'b000,
    TX_START  = 3'b001,
    TX_DATA   = 3'b011,
    TX_PARITY = 3'b010,
    TX_STOP   = 3'b110
  } tx_state_t;

  // receive sequencer, gray coded along start-data-parity-stop
  typedef enum logic [2:0] {
    RX_IDLE   = 3'b000,
    RX_START  = 3'b001,
    RX_DATA   = 3'b011,
    RX_PARITY = 3'b010,
    RX_STOP   = 3'b110
  } rx_state_t;
endpackage

// ===== sim/remote_serial_dev.sv
/*
  remote serial device: sends frames into the channel and decodes the
  frames the channel sends.
  assumes the bench sets character bits, stop bits and parity mode.
*/
`timescale 1ns/1ps
`default_nettype none
module remote_serial_dev #(
  parameter int BIT_CLKS = 64          // clocks per bit
) (
  input  wire logic i_clk,             // base clock
  input  wire logic i_line,            // line from the channel
  output logic      o_line             // line into the channel
);
  int         nb = 8;                  // character bits
  int         ns = 1;                  // stop bits expected
  logic [1:0] pm = 2'b00;              // parity mode
  logic [8:0] got_q[$];                // decoded {parity and stop ok, char}
  initial o_line = 1'b1;               // idle high
  // parity bit for the current mode
  function automatic logic pbit(input logic [7:0] d);
    logic x;
    x = ^(nb == 8 ? d : {1'b0, d[6:0]});
    return pm == 2'b11 ? x : (pm == 2'b10 ? ~x : 1'b0);
  endfunction
  // one bit on the line
  task automatic put(input logic v);
    o_line <= v;
    repeat (BIT_CLKS) @(posedge i_clk);
  endtask
  // one frame, lsb first, optional bad parity or stop
  task automatic send(input logic [7:0] d, input bit bad_p, input bit bad_s);
    put(1'b0);
    for (int i = 0; i < nb; i++) put(d[i]);
    if (pm != 2'b00) put(pbit(d) ^ bad_p);
    put(~bad_s);
    o_line <= 1'b1;
  endtask
  // decoder samples mid bit
  initial begin
    logic [7:0] d;
    bit         ok;
    forever begin
      @(negedge i_line);
      repeat (BIT_CLKS / 2) @(posedge i_clk);
      if (i_line) continue;
      d = 8'h00;
      ok = 1'b1;
      for (int i = 0; i < nb; i++) begin
        repeat (BIT_CLKS) @(posedge i_clk);
        d[i] = i_line;
      end
      if (pm != 2'b00) begin
        repeat (BIT_CLKS) @(posedge i_clk);
        ok &= (i_line == pbit(d));
      end
      for (int i = 0; i < ns; i++) begin
        repeat (BIT_CLKS) @(posedge i_clk);
        ok &= i_line;
      end
      got_q.push_back({ok, d});
    end
  end
endmodule
`default_nettype wire

// ===== sim/serial_channel_chk.sv
/*
  checker for the serial channel: interrupt pulses, line framing and
  axi4-lite handshakes, bound onto the top module.
  assumes the top module ports as declared by the design.
*/
`timescale 1ns/1ps
`default_nettype none
module serial_channel_chk (
  input wire logic        i_clk,         // base clock
  input wire logic        i_rst,         // async reset
  input wire logic        o_tx_line,     // serial output
  input wire logic        o_rx_done_irq, // receive done pulse
  input wire logic        o_tx_done_irq, // transmit done pulse
  input wire logic        o_rx_err_irq,  // receive error pulse
  input wire logic        i_awvalid,     // write address valid
  input wire logic        o_awready,     // write address ready
  input wire logic        i_wvalid,      // write data valid
  input wire logic        o_wready,      // write data ready
  input wire logic [1:0]  o_bresp,       // write response
  input wire logic        o_bvalid,      // write response valid
  input wire logic        i_bready,      // write response ready
  input wire logic        i_arvalid,     // read address valid
  input wire logic        o_arready,     // read address ready
  input wire logic [31:0] o_rdata,       // read data
  input wire logic        o_rvalid,      // read data valid
  input wire logic        i_rready       // read data ready
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // one pulse per frame, never stretched
  AST_RXDONE_PULSE: assert property (o_rx_done_irq |=> !o_rx_done_irq [*8])
    else $error("rx done pulse too long");
  AST_TXDONE_PULSE: assert property ($rose(o_tx_done_irq) |=> !o_tx_done_irq)
    else $error("tx done pulse too long");
  AST_ERR_PULSE: assert property (o_rx_err_irq |=> !o_rx_err_irq)
    else $error("error pulse too long");
  // an error is routed to one request only
  AST_ONE_ROUTE: assert property (!(o_rx_done_irq && o_rx_err_irq))
    else $error("error raised on both requests");
  // tx done lands as the last stop bit leaves the line
  AST_TXDONE_STOP: assert property (o_tx_done_irq |-> $past(o_tx_line))
    else $error("tx done outside stop bit");
  // start bit stays low at least 8 clocks, not a glitch
  AST_START_LEN: assert property ($fell(o_tx_line) |-> !o_tx_line [*8])
    else $error("start bit too short");
  // bus answers hold until taken
  AST_B_HOLD: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped");
  AST_R_HOLD: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data dropped");
  AST_AR_BLOCK: assert property (o_rvalid |-> !o_arready)
    else $error("read address taken while busy");
  AST_R_ANSWER: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read answer late");
  AST_B_ANSWER: assert property (i_awvalid && o_awready && i_wvalid && o_wready
                                 |-> ##[1:2] o_bvalid)
    else $error("write answer late");
  // main scenarios reached
  COV_TXDONE: cover property (o_tx_done_irq);
  COV_ERR: cover property (o_rx_err_irq);
  COV_SLVERR: cover property (o_bvalid && o_bresp == 2'b10);
endmodule
bind serial_channel serial_channel_chk chk_u (.*);
`default_nettype wire

// ===== sim/test_serial_channel.sv
/*
  testbench for the serial channel: register bus master, duplex
  traffic in every mode, errors, disabled paths and reset.
  assumes a baud tick every 4 clocks, so one bit is 64 clocks.
*/
`timescale 1ns/1ps
`default_nettype none
`include "serial_channel_defs.svh"
module test_serial_channel;
  logic        i_clk = 0, i_rst = 1, i_baud_tick = 0, i_rx_line;
  logic [1:0]  tcnt = 0;
  logic        o_tx_line, o_rx_done_irq, o_tx_done_irq, o_rx_err_irq;
  logic [7:0]  i_awaddr = 0, i_araddr = 0;
  logic        i_awvalid = 0, i_wvalid = 0, i_bready = 0, i_arvalid = 0, i_rready = 0;
  logic [31:0] i_wdata = 0, o_rdata, rdat, resp;
  logic [3:0]  i_wstrb = 4'h1;
  logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic [1:0]  o_bresp, o_rresp;
  int          n_errors = 0, checks = 0, n_rd = 0, n_td = 0, n_re = 0;
  serial_channel dut_u (.*);
  remote_serial_dev remote_u (.i_clk(i_clk), .i_line(o_tx_line), .o_line(i_rx_line));
  initial forever #12.5 i_clk = ~i_clk;
  // baud enable and interrupt tallies
  always @(posedge i_clk) begin
    tcnt <= tcnt + 2'd1;
    i_baud_tick <= &tcnt;
  end
  always @(negedge i_clk) begin
    n_rd += o_rx_done_irq;
    n_td += o_tx_done_irq;
    n_re += o_rx_err_irq;
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit ta, tw, tb;
    i_awaddr <= a;
    i_wdata <= d;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    do begin
      @(negedge i_clk);
      ta = i_awvalid & o_awready;
      tw = i_wvalid & o_wready;
      tb = o_bvalid & i_bready;
      resp = {30'h0, o_bresp};
      @(posedge i_clk);
      if (ta) i_awvalid <= 1'b0;
      if (tw) i_wvalid <= 1'b0;
      if (!i_bready) i_bready <= 1'($urandom_range(1, 0));
    end while (!tb);
    i_bready <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic rd(input logic [7:0] a);
    bit ta, tr;
    i_araddr <= a;
    i_arvalid <= 1'b1;
    do begin
      @(negedge i_clk);
      ta = i_arvalid & o_arready;
      tr = o_rvalid & i_rready;
      rdat = o_rdata;
      resp = {30'h0, o_rresp};
      @(posedge i_clk);
      if (ta) i_arvalid <= 1'b0;
      if (!i_rready) i_rready <= 1'($urandom_range(1, 0));
    end while (!tr);
    i_rready <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    cmp(rdat, e);
  endtask
  // read until masked match, bounded
  task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    int i = 0;
    do begin
      rd(a);
      i++;
    end while ((rdat & m) !== v && i < 2000);
  endtask
  function automatic logic [31:0] mode_val(int p, int cl, int sl, int rt);
    return {24'h0, 3'b111, 2'(p), 1'(cl), 1'(sl), 1'(rt)};
  endfunction
  function automatic logic [31:0] exp_char(logic [7:0] d, int cl);
    return cl ? {24'h0, d} : {25'h0, d[6:0]};
  endfunction
  task automatic give_verdict();
    $display("n_errors=%0d checks=%0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #2_000_000;
    n_errors++;
    give_verdict();
  end
  initial begin
    logic [7:0] a, b, c;
    int         p, cl, sl, b_rd, b_td, b_re;
    void'($urandom(1));
    repeat (20) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    rdc(`OFS_MODE, 32'h0000_0001);
    rdc(`OFS_TXSTAT, 32'h0000_0000);
    rdc(`OFS_RXBUF, 32'h0000_00FF);
    rd(8'h14);
    cmp(resp, 32'h0000_0002);
    wr(8'h14, 32'h0);
    cmp(resp, 32'h2);
    wr(`OFS_MODE, 32'h0000_0080);
    wr(`OFS_TXBUF, 32'h0000_0055);
    repeat (800) @(posedge i_clk);
    cmp(remote_u.got_q.size(), 0);
    cmp(o_tx_line, 1);
    for (int k = 0; k < 16; k++) begin
      p = k % 4;
      cl = (k / 4) % 2;
      sl = k / 8;
      wr(`OFS_MODE, mode_val(p, cl, sl, 0));
      remote_u.pm = 2'(p);
      remote_u.nb = cl ? 8 : 7;
      remote_u.ns = sl + 1;
      remote_u.got_q.delete();
      rdc(`OFS_TXSTAT, 32'h0000_0000);
      a = 8'($urandom);
      b = k == 0 ? 8'h00 : 8'($urandom);
      c = k == 1 ? 8'hFF : 8'($urandom);
      b_rd = n_rd;
      b_td = n_td;
      fork
        remote_u.send(c, 0, 0);
        begin
          wr(`OFS_TXBUF, {24'h0, a});
          poll(`OFS_TXSTAT, 32'h0000_0002, 32'h0000_0000);
          wr(`OFS_TXBUF, {24'h0, b});
          rdc(`OFS_TXSTAT, 32'h0000_0003);
        end
      join
      poll(`OFS_TXSTAT, 32'h0000_0003, 32'h0000_0000);
      cmp(rdat, 32'h0000_0000);
      cmp(remote_u.got_q.size(), 2);
      cmp(remote_u.got_q[0], exp_char(a, cl) | 32'h100);
      cmp(remote_u.got_q[1], exp_char(b, cl) | 32'h100);
      cmp(n_td - b_td, 2);
      cmp(n_rd - b_rd, 1);
      rdc(`OFS_RXBUF, exp_char(c, cl));
      rdc(`OFS_ERR, 32'h0000_0000);
      cmp(o_tx_line, 1);
    end
    remote_u.nb = 8;
    for (int r = 0; r < 2; r++) begin
      wr(`OFS_MODE, mode_val(3 - r, 1, 0, r));
      remote_u.pm = 2'(3 - r);
      b_rd = n_rd;
      b_re = n_re;
      remote_u.send(8'hA5, 1, 0);
      rdc(`OFS_ERR, 32'h0000_0004);
      rdc(`OFS_RXBUF, 32'h0000_00A5);
      remote_u.send(8'h5A, 0, 1);
      rdc(`OFS_ERR, 32'h0000_0002);
      rdc(`OFS_RXBUF, 32'h0000_005A);
      remote_u.send(8'h11, 0, 0);
      remote_u.send(8'h22, 0, 0);
      rdc(`OFS_ERR, 32'h0000_0001);
      rdc(`OFS_RXBUF, 32'h0000_0011);
      cmp(n_rd - b_rd, r ? 4 : 1);
      cmp(n_re - b_re, r ? 0 : 3);
    end
    wr(`OFS_MODE, mode_val(0, 1, 0, 0) & 32'h0000_00DF);
    remote_u.pm = 2'b00;
    b_rd = n_rd;
    b_re = n_re;
    remote_u.send(8'h3C, 0, 0);
    remote_u.send(8'h3C, 0, 1);
    cmp(n_rd - b_rd, 0);
    cmp(n_re - b_re, 0);
    rdc(`OFS_RXBUF, 32'h0000_0011);
    wr(`OFS_TXBUF, 32'h0000_0096);
    repeat (200) @(posedge i_clk);
    b_td = n_td;
    i_rst <= 1'b1;
    repeat (20) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (800) @(posedge i_clk);
    cmp(n_td - b_td, 0);
    cmp(o_tx_line, 1);
    rdc(`OFS_TXSTAT, 32'h0000_0000);
    give_verdict();
  end
endmodule
`default_nettype wire
